/* File: pmwc_pkg.sv */
// Package of constants and types for the power mode and wake-up controller.
package pmwc_pkg;
   localparam int          PMWC_NUM_IRQ      = 8;             // Interrupt sources watched.
   localparam int          PMWC_PORTA_W      = 8;             // Port A pins.
   localparam logic [2:0]  PMWC_CKS_SUB      = 3'h7;          // Select pattern for sub clock.
   localparam logic [2:0]  PMWC_CKS_RST      = 3'h0;          // Clock select after reset.
   localparam logic        PMWC_FAST_EN_RST  = 1'b1;          // Fast oscillator on after reset.
   localparam int          PMWC_CLK_MHZ      = 100;           // System clock rate.
   localparam int          PMWC_FAST_STAB_NS = 1000;          // Fast oscillator settle time.
   localparam int          PMWC_SUB_STAB_NS  = 2000;          // Sub oscillator settle time.
   localparam int          PMWC_FAST_STAB_CYC = (PMWC_FAST_STAB_NS * PMWC_CLK_MHZ + 999) / 1000;
   localparam int          PMWC_SUB_STAB_CYC  = (PMWC_SUB_STAB_NS * PMWC_CLK_MHZ + 999) / 1000;
   localparam int          PMWC_CNT_W        = 16;            // Width of the settle counters.
   localparam int          PMWC_DIV_W        = 6;             // Width of the fast clock divider.

   // Operating modes of the controller.
   typedef enum logic [2:0] {
      PMWC_NORMAL,
      PMWC_SLOW,
      PMWC_SLEEP,
      PMWC_IDLE_SUB,
      PMWC_IDLE_BOTH,
      PMWC_IDLE_FAST,
      PMWC_WAKE
   } pmwc_mode_t;

   // Reason for the last wake-up.
   typedef enum logic [1:0] {
      PMWC_WK_NONE,
      PMWC_WK_PORT,
      PMWC_WK_IRQ,
      PMWC_WK_WDT
   } pmwc_wake_t;
endpackage : pmwc_pkg

/* File: pmwc_osc_if.sv */
// Interface between the mode controller and its oscillator settle timer.
`timescale 1ns/1ns
interface pmwc_osc_if;
   logic enable;   // Oscillator requested on.
   logic stable;   // Oscillator has settled.
   modport ctrl  (output enable, input stable);
   modport timer (input enable, output stable);
endinterface : pmwc_osc_if

/* File: pmwc_osc_timer.sv */
// Settle timer that models when an oscillator is stable after enable.
`timescale 1ns/1ns
module pmwc_osc_timer #(
   parameter int SETTLE_CYC = 100
) (
   input  wire logic   sys_clk,
   input  wire logic   srst,
   pmwc_osc_if.timer   osc
);
   import pmwc_pkg::*;

   logic [PMWC_CNT_W-1:0] cnt_r;     // Cycles since enable.
   logic [PMWC_CNT_W-1:0] cnt_nxt;   // Next count.
   logic                  stb_r;     // Stable flag.
   logic                  stb_nxt;   // Next stable flag.

   assign osc.stable = stb_r;

   // The flag clears whenever the oscillator is off and sets after the settle time.
   always_comb begin
      cnt_nxt = cnt_r;
      stb_nxt = stb_r;
      if (!osc.enable) begin
         cnt_nxt = '0;
         stb_nxt = 1'b0;
      end else if (!stb_r) begin
         if (cnt_r >= PMWC_CNT_W'(SETTLE_CYC - 1)) begin
            stb_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   // Registers the counter state.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_r <= '0;
         stb_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         stb_r <= stb_nxt;
      end
   end
endmodule : pmwc_osc_timer

/* File: pmwc_ctrl.sv */
// Power mode and wake-up controller: clock selection, halt modes and wake sources.
`timescale 1ns/1ns
module pmwc_ctrl #(
   parameter int FAST_STAB_CYC = pmwc_pkg::PMWC_FAST_STAB_CYC,
   parameter int SUB_STAB_CYC  = pmwc_pkg::PMWC_SUB_STAB_CYC
) (
   input  wire logic                               sys_clk,
   input  wire logic                               srst,
   input  wire logic [2:0]                         system_clock_select,
   input  wire logic                               fast_osc_keep_on_halt,
   input  wire logic                               sub_osc_keep_on_halt,
   input  wire logic                               fast_osc_enable,
   input  wire logic                               halt_req,
   input  wire logic                               clr_wdt_req,
   input  wire logic                               wdt_enable,
   input  wire logic                               wdt_overflow,
   input  wire logic [pmwc_pkg::PMWC_PORTA_W-1:0]  porta_pins,
   input  wire logic [pmwc_pkg::PMWC_PORTA_W-1:0]  porta_wake_enable,
   input  wire logic [pmwc_pkg::PMWC_NUM_IRQ-1:0]  irq_flags,
   input  wire logic [pmwc_pkg::PMWC_NUM_IRQ-1:0]  irq_enable,
   input  wire logic                               stack_full,
   output logic                                    sys_clk_en,
   output logic                                    slow_mode,
   output logic                                    fast_clk_on,
   output logic                                    sub_clk_on,
   output logic                                    fast_osc_stable_flag,
   output logic                                    cpu_stalled,
   output logic                                    wake_pulse,
   output logic                                    irq_service,
   output logic                                    pc_sp_reset,
   output logic                                    wdt_clear,
   output logic                                    wdt_run,
   output logic                                    power_down_flag,
   output logic                                    watchdog_timeout_flag,
   output pmwc_pkg::pmwc_mode_t                    mode,
   output pmwc_pkg::pmwc_wake_t                    wake_cause
);
   import pmwc_pkg::*;

   pmwc_osc_if fast_if ();   // Fast oscillator request and stable flag.
   pmwc_osc_if sub_if ();    // Sub oscillator request and stable flag.

   pmwc_mode_t            mode_r;       // Current operating mode.
   pmwc_mode_t            mode_nxt;     // Next operating mode.
   pmwc_mode_t            resume_r;     // Mode to return to after wake.
   pmwc_mode_t            resume_nxt;   // Next resume mode.
   pmwc_wake_t            cause_r;      // Last wake cause.
   pmwc_wake_t            cause_nxt;    // Next wake cause.
   logic                  pdf_r;        // Power-down flag.
   logic                  pdf_nxt;      // Next power-down flag.
   logic                  to_r;         // Watchdog timeout flag.
   logic                  to_nxt;       // Next timeout flag.
   logic [PMWC_NUM_IRQ-1:0] mask_r;     // Interrupts pending at halt entry.
   logic [PMWC_NUM_IRQ-1:0] mask_nxt;   // Next mask.
   logic                  svc_r;        // Interrupt service pulse.
   logic                  svc_nxt;      // Next service pulse.
   logic                  pcsp_r;       // PC and SP reset pulse.
   logic                  pcsp_nxt;     // Next PC and SP reset pulse.
   logic                  wclr_r;       // Watchdog clear pulse.
   logic                  wclr_nxt;     // Next watchdog clear pulse.
   logic                  wake_r;       // Wake-up pulse to the core.
   logic                  wake_nxt;     // Next wake pulse.
   logic                  clken_r;      // System clock enable pulse.
   logic                  clken_nxt;    // Next clock enable pulse.
   logic [PMWC_DIV_W-1:0] div_r;        // Fast clock divider.
   logic [PMWC_DIV_W-1:0] div_nxt;      // Next divider value.
   logic [PMWC_DIV_W-1:0] div_mask;     // Divider terminal mask.
   logic                  fast_stb_r;   // Registered fast stable flag.
   logic                  fast_on_r;    // Registered fast clock state.
   logic                  sub_on_r;     // Registered sub clock state.
   logic                  slow_r;       // Registered slow indicator.
   logic                  stall_r;      // Registered stall.
   logic                  wrun_r;       // Registered watchdog run.
   logic [PMWC_PORTA_W-1:0] pa_s1_r;    // Port A synchroniser stage one.
   logic [PMWC_PORTA_W-1:0] pa_s2_r;    // Port A synchroniser stage two.
   logic [PMWC_PORTA_W-1:0] pa_s3_r;    // Port A synchroniser stage three.
   logic [PMWC_PORTA_W-1:0] pa_lvl_r;   // Port A level accepted once stages agree.
   logic [PMWC_PORTA_W-1:0] pa_fall;    // Port A falling edges per pin.
   logic                  port_wake;    // Any enabled pin fell.
   logic                  irq_wake;     // Any unmasked interrupt pending.
   logic                  powered_dn;   // In sleep or an idle mode.

   // Oscillator settle timers for the fast and sub clocks.
   pmwc_osc_timer #(.SETTLE_CYC(FAST_STAB_CYC)) u_fast (
      .sys_clk (sys_clk),
      .srst    (srst),
      .osc     (fast_if.timer)
   );
   pmwc_osc_timer #(.SETTLE_CYC(SUB_STAB_CYC)) u_sub (
      .sys_clk (sys_clk),
      .srst    (srst),
      .osc     (sub_if.timer)
   );

   // A pin falls once the second and third stages agree low after an accepted high.
   genvar gi;
   generate
      for (gi = 0; gi < PMWC_PORTA_W; gi++) begin : g_pa
         assign pa_fall[gi] = porta_wake_enable[gi] & pa_lvl_r[gi] & ~pa_s2_r[gi] &
                              ~pa_s3_r[gi];
      end
   endgenerate

   assign powered_dn = (mode_r == PMWC_SLEEP) || (mode_r == PMWC_IDLE_SUB) ||
                       (mode_r == PMWC_IDLE_BOTH) || (mode_r == PMWC_IDLE_FAST);
   assign port_wake  = |pa_fall;
   assign irq_wake   = |(irq_flags & ~mask_r);

   // Oscillator requests follow the mode; outside sleep and idle the fast one also obeys its enable bit.
   always_comb begin
      fast_if.enable = fast_osc_enable;
      sub_if.enable  = 1'b1;
      case (mode_r)
         PMWC_SLEEP:     begin
            fast_if.enable = 1'b0;
            sub_if.enable  = wdt_enable;
         end
         PMWC_IDLE_SUB:  fast_if.enable = 1'b0;
         PMWC_IDLE_BOTH: begin
            fast_if.enable = 1'b1;
            sub_if.enable  = 1'b1;
         end
         PMWC_IDLE_FAST: begin
            fast_if.enable = 1'b1;
            sub_if.enable  = wdt_enable;
         end
         PMWC_SLOW:      begin
            // A request to leave slow mode must restart the fast oscillator.
            fast_if.enable = fast_osc_enable | (system_clock_select != PMWC_CKS_SUB);
         end
         default:        begin
            // In normal mode the fast clock runs unless the sub clock is selected and the bit is clear.
            fast_if.enable = fast_osc_enable | (system_clock_select != PMWC_CKS_SUB);
         end
      endcase
   end

   // Divider mask: selection n up to 6 gives one enable every two to the n cycles; selection 7 gives one every 64.
   always_comb begin
      div_mask = PMWC_DIV_W'((7'h01 << system_clock_select) - 7'h01);
   end

   // Mode sequencing, flags and the wake-up decision.
   always_comb begin
      mode_nxt   = mode_r;
      resume_nxt = resume_r;
      cause_nxt  = cause_r;
      pdf_nxt    = pdf_r;
      to_nxt     = to_r;
      mask_nxt   = mask_r;
      svc_nxt    = 1'b0;
      pcsp_nxt   = 1'b0;
      wclr_nxt   = 1'b0;
      wake_nxt   = 1'b0;
      clken_nxt  = 1'b0;
      div_nxt    = div_r;
      if (clr_wdt_req) begin
         pdf_nxt = 1'b0;
      end
      case (mode_r)
         PMWC_NORMAL, PMWC_SLOW: begin
            // Clock enable pulses only once the selected source has settled.
            if (mode_r == PMWC_SLOW) begin
               clken_nxt = sub_if.stable;
               if (system_clock_select != PMWC_CKS_SUB && fast_if.stable) begin
                  mode_nxt = PMWC_NORMAL;
                  div_nxt  = '0;
               end
            end else begin
               if (fast_if.stable) begin
                  clken_nxt = ((div_r & div_mask) == '0);
                  div_nxt   = div_r + 1'b1;
               end
               if (system_clock_select == PMWC_CKS_SUB && sub_if.stable) begin
                  mode_nxt = PMWC_SLOW;
               end
            end
            if (halt_req) begin
               clken_nxt  = 1'b0;
               resume_nxt = mode_r;
               pdf_nxt    = 1'b1;
               to_nxt     = 1'b0;
               wclr_nxt   = 1'b1;
               mask_nxt   = irq_flags;
               cause_nxt  = PMWC_WK_NONE;
               case ({fast_osc_keep_on_halt, sub_osc_keep_on_halt})
                  2'b00:   mode_nxt = PMWC_SLEEP;
                  2'b01:   mode_nxt = PMWC_IDLE_SUB;
                  2'b11:   mode_nxt = PMWC_IDLE_BOTH;
                  default: mode_nxt = PMWC_IDLE_FAST;
               endcase
            end
         end
         PMWC_SLEEP, PMWC_IDLE_SUB, PMWC_IDLE_BOTH, PMWC_IDLE_FAST: begin
            // Execution is frozen; only the three wake sources leave this state.
            if (wdt_overflow) begin
               to_nxt    = 1'b1;
               pcsp_nxt  = 1'b1;
               cause_nxt = PMWC_WK_WDT;
               mode_nxt  = PMWC_WAKE;
            end else if (port_wake) begin
               cause_nxt = PMWC_WK_PORT;
               mode_nxt  = PMWC_WAKE;
            end else if (irq_wake) begin
               cause_nxt = PMWC_WK_IRQ;
               mode_nxt  = PMWC_WAKE;
            end
         end
         PMWC_WAKE: begin
            // Hold the core until the clock it resumes on is stable.
            if ((resume_r == PMWC_SLOW) ? sub_if.stable : fast_if.stable) begin
               mode_nxt = resume_r;
               wake_nxt = 1'b1;
               div_nxt  = '0;
               mask_nxt = '0;
               if (cause_r == PMWC_WK_IRQ) begin
                  svc_nxt = |(irq_flags & ~mask_r & irq_enable) & ~stack_full;
               end
            end
         end
         default: mode_nxt = PMWC_NORMAL;
      endcase
   end

   // Registers the controller state and its outputs.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_r     <= PMWC_NORMAL;
         resume_r   <= PMWC_NORMAL;
         cause_r    <= PMWC_WK_NONE;
         pdf_r      <= 1'b0;
         to_r       <= 1'b0;
         mask_r     <= '0;
         svc_r      <= 1'b0;
         pcsp_r     <= 1'b0;
         wclr_r     <= 1'b0;
         wake_r     <= 1'b0;
         clken_r    <= 1'b0;
         div_r      <= '0;
         fast_stb_r <= 1'b0;
         fast_on_r  <= 1'b0;
         sub_on_r   <= 1'b0;
         slow_r     <= 1'b0;
         stall_r    <= 1'b0;
         wrun_r     <= 1'b0;
         pa_s1_r    <= '1;
         pa_s2_r    <= '1;
         pa_s3_r    <= '1;
         pa_lvl_r   <= '1;
      end else begin
         mode_r     <= mode_nxt;
         resume_r   <= resume_nxt;
         cause_r    <= cause_nxt;
         pdf_r      <= pdf_nxt;
         to_r       <= to_nxt;
         mask_r     <= mask_nxt;
         svc_r      <= svc_nxt;
         pcsp_r     <= pcsp_nxt;
         wclr_r     <= wclr_nxt;
         wake_r     <= wake_nxt;
         clken_r    <= clken_nxt;
         div_r      <= div_nxt;
         fast_stb_r <= fast_if.stable;
         fast_on_r  <= fast_if.enable;
         sub_on_r   <= sub_if.enable;
         slow_r     <= (mode_r == PMWC_SLOW);
         stall_r    <= powered_dn || (mode_r == PMWC_WAKE) || halt_req;
         wrun_r     <= wdt_enable && !wclr_nxt;
         pa_s1_r    <= porta_pins;
         pa_s2_r    <= pa_s1_r;
         pa_s3_r    <= pa_s2_r;
         pa_lvl_r   <= (pa_s2_r & pa_s3_r) | (pa_lvl_r & (pa_s2_r | pa_s3_r)); // Holds on disagree.
      end
   end

   assign sys_clk_en            = clken_r;
   assign slow_mode             = slow_r;
   assign fast_clk_on           = fast_on_r;
   assign sub_clk_on            = sub_on_r;
   assign fast_osc_stable_flag  = fast_stb_r;
   assign cpu_stalled           = stall_r;
   assign wake_pulse            = wake_r;
   assign irq_service           = svc_r;
   assign pc_sp_reset           = pcsp_r;
   assign wdt_clear             = wclr_r;
   assign wdt_run               = wrun_r;
   assign power_down_flag       = pdf_r;
   assign watchdog_timeout_flag = to_r;
   assign mode                  = mode_r;
   assign wake_cause            = cause_r;
endmodule : pmwc_ctrl

/* File: pmwc_ctrl_sva.sv */
// Concurrent checks on the ports of the power mode and wake-up controller.
`timescale 1ns/1ns
module pmwc_ctrl_sva #(
   parameter int SUB_STAB_CYC = 200
) (
   input wire logic                 sys_clk,
   input wire logic                 srst,
   input wire logic [2:0]           system_clock_select,
   input wire logic                 fast_osc_keep_on_halt,
   input wire logic                 sub_osc_keep_on_halt,
   input wire logic                 halt_req,
   input wire logic                 clr_wdt_req,
   input wire logic                 wdt_enable,
   input wire logic                 wdt_overflow,
   input wire logic                 sys_clk_en,
   input wire logic                 slow_mode,
   input wire logic                 fast_clk_on,
   input wire logic                 sub_clk_on,
   input wire logic                 fast_osc_stable_flag,
   input wire logic                 cpu_stalled,
   input wire logic                 wake_pulse,
   input wire logic                 irq_service,
   input wire logic                 pc_sp_reset,
   input wire logic                 wdt_clear,
   input wire logic                 wdt_run,
   input wire logic                 power_down_flag,
   input wire logic                 watchdog_timeout_flag,
   input wire pmwc_pkg::pmwc_mode_t mode,
   input wire pmwc_pkg::pmwc_wake_t wake_cause
);
   import pmwc_pkg::*;
   localparam int SLOW_MAX = SUB_STAB_CYC + 8; // Longest wait for slow mode.
   logic       run_mode;  // Controller accepts a halt.
   logic       down;      // Controller sits in sleep or an idle mode.
   pmwc_mode_t halt_mode; // Mode that the keep bits ask for.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   assign run_mode = (mode == PMWC_NORMAL) || (mode == PMWC_SLOW);
   assign down = mode inside {PMWC_SLEEP, PMWC_IDLE_SUB, PMWC_IDLE_BOTH, PMWC_IDLE_FAST};
   // Maps the two keep bits onto the halt mode.
   always_comb begin
      case ({fast_osc_keep_on_halt, sub_osc_keep_on_halt})
         2'b00:   halt_mode = PMWC_SLEEP;
         2'b01:   halt_mode = PMWC_IDLE_SUB;
         2'b10:   halt_mode = PMWC_IDLE_FAST;
         default: halt_mode = PMWC_IDLE_BOTH;
      endcase
   end
   property p_halt_enter;
      halt_req && run_mode |=>
         power_down_flag && !watchdog_timeout_flag && wdt_clear && cpu_stalled;
   endproperty
   a_halt_enter: assert property (p_halt_enter) else $error("halt entry wrong");
   property p_halt_mode;
      halt_req && run_mode |=> mode == $past(halt_mode);
   endproperty
   a_halt_mode: assert property (p_halt_mode) else $error("halt mode wrong");
   property p_sleep_clk;
      mode == PMWC_SLEEP && $past(mode) == PMWC_SLEEP |-> !fast_clk_on && !sys_clk_en;
   endproperty
   a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clock on");
   property p_idle_clk;
      down && mode != PMWC_SLEEP && $stable(mode) |->
         (fast_clk_on == (mode != PMWC_IDLE_SUB)) && (sub_clk_on || mode == PMWC_IDLE_FAST);
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("idle clocks wrong");
   property p_wdt_wake;
      wdt_overflow && down |=>
         mode == PMWC_WAKE && watchdog_timeout_flag && pc_sp_reset && wake_cause == PMWC_WK_WDT;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");
   property p_pdf_clear;
      clr_wdt_req && !halt_req |=> !power_down_flag;
   endproperty
   a_pdf_clear: assert property (p_pdf_clear) else $error("pdf not cleared");
   property p_slow_enter;
      mode == PMWC_NORMAL && system_clock_select == PMWC_CKS_SUB && !halt_req
         |-> ##[1:SLOW_MAX] mode == PMWC_SLOW;
   endproperty
   a_slow_enter: assert property (p_slow_enter) else $error("slow mode late");
   property p_wake_rel;
      wake_pulse |-> run_mode && (mode == PMWC_SLOW || fast_osc_stable_flag);
   endproperty
   a_wake_rel: assert property (p_wake_rel) else $error("clock released early");
   property p_resume;
      wake_pulse |=> !cpu_stalled;
   endproperty
   a_resume: assert property (p_resume) else $error("core not resumed");
   property p_irq_svc;
      irq_service |-> wake_pulse && wake_cause == PMWC_WK_IRQ;
   endproperty
   a_irq_svc: assert property (p_irq_svc) else $error("service without wake");
   property p_stab_rise;
      $rose(fast_osc_stable_flag) |-> $past(fast_clk_on, 3);
   endproperty
   a_stab_rise: assert property (p_stab_rise) else $error("stable too soon");
   property p_wdt_stop;
      !wdt_enable && !$past(wdt_enable) |-> !wdt_run;
   endproperty
   a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog runs off");
endmodule : pmwc_ctrl_sva
bind pmwc_ctrl pmwc_ctrl_sva #(.SUB_STAB_CYC(SUB_STAB_CYC)) u_sva (.sys_clk, .srst,
   .system_clock_select, .fast_osc_keep_on_halt, .sub_osc_keep_on_halt, .halt_req,
   .clr_wdt_req, .wdt_enable, .wdt_overflow, .sys_clk_en, .slow_mode, .fast_clk_on,
   .sub_clk_on, .fast_osc_stable_flag, .cpu_stalled, .wake_pulse, .irq_service, .pc_sp_reset,
   .wdt_clear, .wdt_run, .power_down_flag, .watchdog_timeout_flag, .mode, .wake_cause);

/* File: pmwc_cpu_model.sv */
// Model of the core that issues halt and resumes on wake-up.
`timescale 1ns/1ns
module pmwc_cpu_model (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       halt_cmd,
   input  wire logic       cpu_stalled,
   input  wire logic       wake_pulse,
   output logic            halt_req,
   output logic [7:0]      resumes
);
   logic       halt_nxt; // Next halt strobe.
   logic [7:0] res_nxt;  // Next resume count.
   // A halt lasts one cycle and is never issued while the core is stalled.
   always_comb begin
      halt_nxt = halt_cmd && !cpu_stalled && !halt_req;
      res_nxt  = resumes + {7'h00, wake_pulse};
   end
   // Registers the strobe and the resume count.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         halt_req <= 1'b0;
         resumes  <= 8'h00;
      end else begin
         halt_req <= halt_nxt;
         resumes  <= res_nxt;
      end
   end
endmodule : pmwc_cpu_model

/* File: tb_top.sv */
// Self-checking testbench for the power mode and wake-up controller.
`timescale 1ns/1ns
module tb_top;
   import pmwc_pkg::*;
   logic       sys_clk, srst, halt_cmd, halt_req, clr_wdt_req, wdt_enable, wdt_overflow;
   logic       fast_osc_keep_on_halt, sub_osc_keep_on_halt, fast_osc_enable, stack_full;
   logic [2:0] system_clock_select;
   logic [7:0] porta_pins, porta_wake_enable, irq_flags, irq_enable, resumes, cnt;
   logic       sys_clk_en, slow_mode, fast_clk_on, sub_clk_on, fast_osc_stable_flag;
   logic       cpu_stalled, wake_pulse, irq_service, pc_sp_reset, wdt_clear, wdt_run;
   logic       power_down_flag, watchdog_timeout_flag;
   pmwc_mode_t mode;
   pmwc_wake_t wake_cause;
   int         errors, checks_done;
   pmwc_mode_t exp_mode [4] = '{PMWC_SLEEP, PMWC_IDLE_SUB, PMWC_IDLE_FAST, PMWC_IDLE_BOTH};
   pmwc_wake_t exp_wake [5] = '{PMWC_WK_WDT, PMWC_WK_PORT, PMWC_WK_IRQ, PMWC_WK_IRQ,
                               PMWC_WK_IRQ};
   pmwc_ctrl #(.FAST_STAB_CYC(4), .SUB_STAB_CYC(4)) u_dut (.sys_clk, .srst,
      .system_clock_select, .fast_osc_keep_on_halt, .sub_osc_keep_on_halt, .fast_osc_enable,
      .halt_req, .clr_wdt_req, .wdt_enable, .wdt_overflow, .porta_pins, .porta_wake_enable,
      .irq_flags, .irq_enable, .stack_full, .sys_clk_en, .slow_mode, .fast_clk_on,
      .sub_clk_on, .fast_osc_stable_flag, .cpu_stalled, .wake_pulse, .irq_service,
      .pc_sp_reset, .wdt_clear, .wdt_run, .power_down_flag, .watchdog_timeout_flag, .mode,
      .wake_cause);
   pmwc_cpu_model u_cpu (.sys_clk, .srst, .halt_cmd, .cpu_stalled, .wake_pulse, .halt_req,
      .resumes);
   // Compares one value and reports a mismatch at once.
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // Waits for a wake pulse (sel 1) or a settled mode (sel 0), bounded.
   task automatic wait_for(input int sel, input pmwc_mode_t m);
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 60) begin
         @(negedge sys_clk);
         n++;
         ok = (sel == 1) ? wake_pulse === 1'b1 :
              (mode === m && (m != PMWC_NORMAL || fast_osc_stable_flag === 1'b1));
      end
      if (!ok) begin
         errors++;
         stop_test();
      end
   endtask : wait_for
   // Asks the core for a halt and checks the power-down entry.
   task automatic do_halt(input logic [1:0] keeps);
      {fast_osc_keep_on_halt, sub_osc_keep_on_halt} = keeps;
      halt_cmd = 1'b1;
      @(negedge sys_clk);
      halt_cmd = 1'b0;
      repeat (3) @(negedge sys_clk);
      check("mode", 8'(mode), 8'(exp_mode[keeps]));
      check("pdf", 8'(power_down_flag), 8'h01);
      check("timeout", 8'(watchdog_timeout_flag), 8'h00);
      check("stalled", 8'(cpu_stalled), 8'h01);
   endtask : do_halt
   // Free-running system clock.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Main sequence: reset, dividers, slow mode, four halt modes and wake sources.
   initial begin
      errors = 0;
      checks_done = 0;
      {srst, fast_osc_enable, wdt_enable} = 3'h7;
      {halt_cmd, clr_wdt_req, wdt_overflow, stack_full} = 4'h0;
      {fast_osc_keep_on_halt, sub_osc_keep_on_halt, system_clock_select} = 5'h00;
      {porta_pins, porta_wake_enable, irq_flags, irq_enable} = 32'hFF00_0000;
      repeat (20) @(negedge sys_clk);
      check("rst_mode", 8'(mode), 8'(PMWC_NORMAL));
      check("rst_pdf", 8'(power_down_flag), 8'h00);
      check("rst_stable", 8'(fast_osc_stable_flag), 8'h00);
      srst = 1'b0;
      wait_for(0, PMWC_NORMAL);
      for (int d = 0; d < 7; d++) begin
         system_clock_select = 3'(d);
         repeat (8) @(negedge sys_clk);
         cnt = 8'h00;
         repeat (64) begin
            @(negedge sys_clk);
            cnt = cnt + 8'(sys_clk_en);
         end
         check("ticks", cnt, 8'(64 >> d));
      end
      fast_osc_enable = 1'b0;
      system_clock_select = PMWC_CKS_SUB;
      wait_for(0, PMWC_SLOW);
      repeat (8) @(negedge sys_clk);
      check("slow", 8'(slow_mode), 8'h01);
      check("slow_stable", 8'(fast_osc_stable_flag), 8'h00);
      system_clock_select = 3'h0;
      wait_for(0, PMWC_NORMAL);
      @(negedge sys_clk);
      check("normal", 8'(slow_mode), 8'h00);
      fast_osc_enable = 1'b1;
      for (int k = 0; k < 5; k++) begin
         wdt_enable = (k != 1);
         irq_enable = (k == 2 || k == 4) ? 8'hFF : 8'h00;
         stack_full = (k == 4);
         irq_flags = (k == 3) ? 8'h02 : 8'h00;
         do_halt(2'(k));
         if (k == 0) begin
            check("wdt_run", 8'(wdt_run), 8'h01);
            wdt_overflow = 1'b1;
            @(negedge sys_clk);
            wdt_overflow = 1'b0;
            check("timeout", 8'(watchdog_timeout_flag), 8'h01);
            check("pc_sp", 8'(pc_sp_reset), 8'h01);
            check("pdf_kept", 8'(power_down_flag), 8'h01);
         end else if (k == 1) begin
            check("wdt_stop", 8'(wdt_run), 8'h00);
            porta_wake_enable = 8'h01;
            porta_pins = 8'hFD;
            repeat (10) @(negedge sys_clk);
            check("pin_off", 8'(cpu_stalled), 8'h01);
            porta_pins = 8'hFC;
         end else if (k == 2 || k == 4) begin
            irq_flags = 8'h01;
         end else begin
            repeat (10) @(negedge sys_clk);
            check("pending", 8'(cpu_stalled), 8'h01);
            irq_flags = 8'h06;
         end
         wait_for(1, PMWC_WAKE);
         check("cause", 8'(wake_cause), 8'(exp_wake[k]));
         check("service", 8'(irq_service), 8'(k == 2));
         @(negedge sys_clk);
         check("resumed", 8'(cpu_stalled), 8'h00);
         {porta_pins, irq_flags} = 16'hFF00;
      end
      clr_wdt_req = 1'b1;
      @(negedge sys_clk);
      clr_wdt_req = 1'b0;
      @(negedge sys_clk);
      check("pdf_clr", 8'(power_down_flag), 8'h00);
      check("resumes", resumes, 8'h05);
      stop_test();
   end
endmodule : tb_top
